// [shared/eepac_pkg.sv]
package eepac_pkg;
   // ************************************************************
   // control register layout and map
   // ************************************************************
   localparam logic [15:0] EEPAC_CTRL_ADDR = 16'h103B;
   localparam logic [15:0] EEPAC_ARRAY_BASE = 16'hB600;
   localparam int EEPAC_ARRAY_AW = 9;
   localparam int EEPAC_LAT_BIT = 1;
   localparam int EEPAC_PGM_BIT = 0;
   localparam int EEPAC_ERASE_BIT = 2;
   localparam logic [7:0] EEPAC_CTRL_RESET = 8'h00;
   localparam logic [7:0] EEPAC_CTRL_LATCH = 8'h02;
   localparam logic [7:0] EEPAC_CTRL_PROGRAM = 8'h03;
   localparam logic [7:0] EEPAC_CTRL_ERASE_LAT = 8'h06;
   localparam logic [7:0] EEPAC_CTRL_ERASE_GO = 8'h07;
   localparam logic [7:0] EEPAC_ERASED = 8'hFF;
   localparam logic [7:0] EEPAC_BLANK_READ = 8'hFF;
   // ************************************************************
   // timing
   // ************************************************************
   localparam int EEPAC_CLK_MHZ = 125;
   localparam int EEPAC_HV_TIME_MS = 10;
   localparam int EEPAC_HV_CYCLES = EEPAC_HV_TIME_MS * 1000 * EEPAC_CLK_MHZ;
endpackage

// [shared/eepac_if.sv]
`timescale 1ns/1ps
interface eepac_if;
   logic [15:0] addr;
   logic [7:0] wdata;
   logic wr;
   logic rd;
   logic [7:0] rdata;
   logic rvalid;
   logic busy;
   modport dev (input addr, input wdata, input wr, input rd, output rdata, output rvalid,
      output busy);
   modport cpu (output addr, output wdata, output wr, output rd, input rdata, input rvalid,
      input busy);
endinterface

// [logic/eepac_device.sv]
`timescale 1ns/1ps
// Notes on behaviour
// - erase then program yields any new value
// - program only clears bits, ones stay
// - software may clear more bits later
// - software avoids mixed clear and mask patterns
// - latch select unmaps the array
// - software holds operation about 10 ms
// - array access while active returns no data
// - voltage stays on until software ends
// - power fail should raise nonmaskable interrupt
// - rewrite option word only on error
// - 02 hex sets latch select alone
// - 03 hex adds program voltage enable
// - clearing control restores read mode
module eepac_device
   import eepac_pkg::*;
#(
   parameter int ARRAY_AW = EEPAC_ARRAY_AW
) (
   input wire logic clk,
   input wire logic reset,
   eepac_if.dev bus,
   output logic array_latch_select,
   output logic program_voltage_enable,
   output logic [15:0] hv_cycles
);
   localparam int DEPTH = 1 << ARRAY_AW;

   // ************************************************************
   // state
   // ************************************************************
   logic [7:0] mem [DEPTH];
   logic erase_sel;
   logic next_latch;
   logic next_pgm;
   logic next_erase;
   logic [ARRAY_AW-1:0] lat_addr;
   logic [ARRAY_AW-1:0] next_lat_addr;
   logic [7:0] lat_data;
   logic [7:0] next_lat_data;
   logic lat_full;
   logic next_lat_full;
   logic [7:0] rdata, next_rdata;
   logic rvalid, next_rvalid;
   logic [15:0] next_hv;
   logic ctrl_wr;
   logic cell_we;
   logic [7:0] cell_old;
   logic [7:0] cell_wdata;

   // ************************************************************
   // bus decode
   // ************************************************************
   function automatic logic in_array(input logic [15:0] a);
      in_array = (a >= EEPAC_ARRAY_BASE) && (a < EEPAC_ARRAY_BASE + 16'(DEPTH));
   endfunction

   function automatic logic is_ctrl(input logic [15:0] a);
      is_ctrl = (a == EEPAC_CTRL_ADDR);
   endfunction

   function automatic logic [ARRAY_AW-1:0] cell_index(input logic [15:0] a);
      cell_index = ARRAY_AW'(a - EEPAC_ARRAY_BASE);
   endfunction

   function automatic logic [7:0] ctrl_image(input logic er, input logic lat, input logic pgm);
      ctrl_image = {5'h00, er, lat, pgm};
   endfunction

   // erase forces ones; program can only pull ones down to zero
   function automatic logic [7:0] cell_result(input logic [7:0] old, input logic [7:0] d,
         input logic er);
      cell_result = er ? EEPAC_ERASED : (old & d);
   endfunction

   // ************************************************************
   // control register
   // ************************************************************
   // erase select rides on the same write; it steers the cell effect and shows in the control read image
   always_comb begin
      ctrl_wr = bus.wr && is_ctrl(bus.addr);
      next_latch = array_latch_select;
      next_pgm = program_voltage_enable;
      next_erase = erase_sel;
      if (ctrl_wr) begin
         next_latch = bus.wdata[EEPAC_LAT_BIT];
         next_erase = bus.wdata[EEPAC_ERASE_BIT];
         // voltage only if latch already set before this write
         next_pgm = bus.wdata[EEPAC_PGM_BIT] && array_latch_select;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         array_latch_select <= 1'b0;
         program_voltage_enable <= 1'b0;
         erase_sel <= 1'b0;
      end else begin
         array_latch_select <= next_latch;
         program_voltage_enable <= next_pgm;
         erase_sel <= next_erase;
      end
   end

   // ************************************************************
   // array write latch
   // ************************************************************
   // writes are only caught with voltage off, so the target can't move mid-phase
   always_comb begin
      next_lat_addr = lat_addr;
      next_lat_data = lat_data;
      next_lat_full = lat_full;
      if (ctrl_wr && !bus.wdata[EEPAC_LAT_BIT]) begin
         next_lat_full = 1'b0;
      end else if (bus.wr && in_array(bus.addr) && array_latch_select
            && !program_voltage_enable) begin
         next_lat_addr = cell_index(bus.addr);
         next_lat_data = bus.wdata;
         next_lat_full = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         lat_addr <= '0;
         lat_data <= EEPAC_ERASED;
         lat_full <= 1'b0;
      end else begin
         lat_addr <= next_lat_addr;
         lat_data <= next_lat_data;
         lat_full <= next_lat_full;
      end
   end

   // ************************************************************
   // read path
   // ************************************************************
   // every read answers next cycle, so the cpu side never stalls
   always_comb begin
      next_rdata = EEPAC_BLANK_READ;
      next_rvalid = 1'b0;
      if (bus.rd) begin
         next_rvalid = 1'b1;
         if (is_ctrl(bus.addr)) begin
            next_rdata = ctrl_image(erase_sel, array_latch_select, program_voltage_enable);
         end else if (in_array(bus.addr) && !array_latch_select) begin
            next_rdata = mem[cell_index(bus.addr)];
         end
         // else blank: array unmapped while latched
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         rdata <= EEPAC_BLANK_READ;
         rvalid <= 1'b0;
      end else begin
         rdata <= next_rdata;
         rvalid <= next_rvalid;
      end
   end

   // ************************************************************
   // voltage-on counter
   // ************************************************************
   // saturates so a badly stretched phase never wraps to look short
   always_comb begin
      next_hv = hv_cycles;
      if (next_pgm && !program_voltage_enable) begin
         next_hv = 16'h0000;
      end else if (program_voltage_enable && hv_cycles != 16'hFFFF) begin
         next_hv = hv_cycles + 16'h0001;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         hv_cycles <= 16'h0000;
      end else begin
         hv_cycles <= next_hv;
      end
   end

   // ************************************************************
   // cell array: effect applied while voltage held, no timeout
   // ************************************************************
   // cells act every voltage cycle while the latch is full, so a stretched phase just repeats the
   // same idempotent effect
   always_comb begin
      cell_old = mem[lat_addr];
      cell_we = program_voltage_enable && lat_full;
      cell_wdata = cell_result(cell_old, lat_data, erase_sel);
   end

   always_ff @(posedge clk) begin
      if (cell_we) begin
         mem[lat_addr] <= cell_wdata;
      end
   end

   assign bus.rdata = rdata;
   assign bus.rvalid = rvalid;
   assign bus.busy = array_latch_select;
endmodule

// [logic/eepac_cpu.sv]
`timescale 1ns/1ps
module eepac_cpu
   import eepac_pkg::*;
#(
   parameter int HV_CYCLES = EEPAC_HV_CYCLES
) (
   input wire logic clk,
   input wire logic reset,
   eepac_if.cpu bus,
   input wire logic start,
   input wire logic erase_first,
   input wire logic [15:0] addr,
   input wire logic [7:0] data,
   output logic done,
   output logic active
);
   typedef enum {S_IDLE, S_LAT, S_WR, S_GO, S_WAIT, S_OFF} eepac_st_e;
   eepac_st_e st, next_st;
   logic erase_ph, next_erase_ph;
   logic [31:0] cnt, next_cnt;
   logic [15:0] a_q, next_a;
   logic [7:0] d_q, next_d;
   logic done_q, next_done;
   logic active_q, next_active;
   logic [15:0] o_addr;
   logic [7:0] o_wdata;
   logic o_wr;

   always_comb begin
      next_st = st;
      next_erase_ph = erase_ph;
      next_cnt = cnt;
      next_a = a_q;
      next_d = d_q;
      next_done = 1'b0;
      o_addr = EEPAC_CTRL_ADDR;
      o_wdata = EEPAC_CTRL_RESET;
      o_wr = 1'b0;
      case (st)
         S_IDLE: begin
            if (start) begin
               next_a = addr;
               next_d = data;
               next_erase_ph = erase_first;
               next_st = S_LAT;
            end
         end
         S_LAT: begin
            o_wr = 1'b1;
            o_wdata = erase_ph ? EEPAC_CTRL_ERASE_LAT : EEPAC_CTRL_LATCH;
            next_st = S_WR;
         end
         S_WR: begin
            o_wr = 1'b1;
            o_addr = a_q;
            o_wdata = erase_ph ? EEPAC_ERASED : d_q;
            next_st = S_GO;
         end
         S_GO: begin
            o_wr = 1'b1;
            o_wdata = erase_ph ? EEPAC_CTRL_ERASE_GO : EEPAC_CTRL_PROGRAM;
            next_cnt = 32'h0;
            next_st = S_WAIT;
         end
         S_WAIT: begin
            next_cnt = cnt + 32'h1;
            // a started phase always runs out, so shutdown code can finish it
            if (cnt >= 32'(HV_CYCLES) - 32'h1) begin
               next_st = S_OFF;
            end
         end
         S_OFF: begin
            o_wr = 1'b1;
            o_wdata = EEPAC_CTRL_RESET;
            if (erase_ph) begin
               next_erase_ph = 1'b0;
               next_st = S_LAT;
            end else begin
               next_done = 1'b1;
               next_st = S_IDLE;
            end
         end
         default: next_st = S_IDLE;
      endcase
      next_active = (next_st != S_IDLE);
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         st <= S_IDLE;
         erase_ph <= 1'b0;
         cnt <= 32'h0;
         a_q <= 16'h0000;
         d_q <= 8'h00;
         done_q <= 1'b0;
         active_q <= 1'b0;
      end else begin
         st <= next_st;
         erase_ph <= next_erase_ph;
         cnt <= next_cnt;
         a_q <= next_a;
         d_q <= next_d;
         done_q <= next_done;
         active_q <= next_active;
      end
   end

   assign bus.addr = o_addr;
   assign bus.wdata = o_wdata;
   assign bus.wr = o_wr;
   assign bus.rd = 1'b0;
   assign done = done_q;
   assign active = active_q;
endmodule

// [verif/eepac_asserts.sv]
`timescale 1ns/1ps
module eepac_asserts
   import eepac_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic [15:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic busy,
   input wire logic array_latch_select,
   input wire logic program_voltage_enable
);
   // ***************************************
   // control bit relations
   // ***************************************
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   logic ctrl_wr;
   assign ctrl_wr = wr && addr == EEPAC_CTRL_ADDR;
   sequence s_ctrl_wr;
      ctrl_wr;
   endsequence
   sequence s_clear;
      ctrl_wr && wdata == 8'h00;
   endsequence
   a_reset_clears_ctrl: assert property (disable iff (1'b0) reset |=>
      !array_latch_select && !program_voltage_enable) else $error("ctrl not cleared");
   a_voltage_needs_latch: assert property ($rose(program_voltage_enable) |->
      $past(array_latch_select)) else $error("voltage without latch");
   a_latch_from_write: assert property (s_ctrl_wr |=>
      array_latch_select == $past(wdata[EEPAC_LAT_BIT])) else $error("latch bit wrong");
   a_voltage_from_write: assert property (s_ctrl_wr ##0 array_latch_select |=>
      program_voltage_enable == $past(wdata[EEPAC_PGM_BIT])) else $error("voltage bit wrong");
   a_clear_restores: assert property (s_clear |=>
      !array_latch_select && !program_voltage_enable && !busy) else $error("not cleared");
   a_busy_tracks_latch: assert property (busy == array_latch_select)
      else $error("busy differs");
   a_voltage_held: assert property (program_voltage_enable && !ctrl_wr |=>
      program_voltage_enable) else $error("voltage dropped");
   a_latch_held: assert property (array_latch_select && !ctrl_wr |=>
      array_latch_select) else $error("latch dropped");
endmodule

// [verif/testbench.sv]
`timescale 1ns/1ps
module testbench
   import eepac_pkg::*;
;
   localparam int HV = 20;
   logic clk = 0, reset = 1, start = 0, erase_first = 0;
   logic [15:0] addr = 16'hB600, a;
   logic [7:0] data = 8'h00, lwd, o, n;
   logic done, active, lat_a, pgm_a, lat_b, pgm_b;
   logic [15:0] hv_b;
   int fail_count = 0, num_checks = 0, seed = 93399, cycles = 0, hv_n = 0, k, m;
   logic [7:0] q[$], ex[$];
   eepac_if bus_a();
   eepac_if bus_b();
   always #4 clk = ~clk;
   eepac_cpu #(.HV_CYCLES(HV)) eepac_cpu_inst (.clk(clk), .reset(reset), .bus(bus_a),
      .start(start), .erase_first(erase_first), .addr(addr), .data(data), .done(done),
      .active(active));
   eepac_device eepac_device_inst (.clk(clk), .reset(reset), .bus(bus_a),
      .array_latch_select(lat_a), .program_voltage_enable(pgm_a), .hv_cycles());
   eepac_device eepac_device_inst_b (.clk(clk), .reset(reset), .bus(bus_b),
      .array_latch_select(lat_b), .program_voltage_enable(pgm_b), .hv_cycles(hv_b));
   eepac_asserts eepac_asserts_inst (.clk(clk), .reset(reset), .addr(bus_a.addr),
      .wdata(bus_a.wdata), .wr(bus_a.wr), .busy(bus_a.busy), .array_latch_select(lat_a),
      .program_voltage_enable(pgm_a));
   // ***************************************
   // monitor and tasks
   // ***************************************
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         fail_count++;
         summarize();
      end
      if (pgm_a) hv_n++;
      if (bus_a.wr && bus_a.addr == EEPAC_CTRL_ADDR) q.push_back(bus_a.wdata);
      else if (bus_a.wr) lwd = bus_a.wdata;
   end
   task summarize;
      $display("checks=%0d mismatches=%0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task bw(input logic [15:0] ad, input logic [7:0] d);
      @(posedge clk);
      bus_b.addr <= ad;
      bus_b.wdata <= d;
      bus_b.wr <= 1'b1;
      @(posedge clk);
      bus_b.wr <= 1'b0;
   endtask
   task br(input logic [15:0] ad, input logic [7:0] e);
      @(posedge clk);
      bus_b.addr <= ad;
      bus_b.rd <= 1'b1;
      @(posedge clk);
      bus_b.rd <= 1'b0;
      #1;
      chk(16'(bus_b.rvalid), 16'h0001);
      chk(16'(bus_b.rdata), 16'(e));
   endtask
   // bus is left latched across the wait so stray reads must come back blank
   task op(input logic [7:0] d, input logic er, input logic [7:0] e);
      bw(EEPAC_CTRL_ADDR, er ? EEPAC_CTRL_ERASE_LAT : EEPAC_CTRL_LATCH);
      bw(a, d);
      br(a, EEPAC_BLANK_READ);
      bw(EEPAC_CTRL_ADDR, er ? EEPAC_CTRL_ERASE_GO : EEPAC_CTRL_PROGRAM);
      repeat (HV) @(posedge clk);
      br(a, EEPAC_BLANK_READ);
      bw(EEPAC_CTRL_ADDR, EEPAC_CTRL_RESET);
      #1;
      chk(hv_b, 16'(HV + 4));
      br(a, e);
   endtask
   initial begin
      bus_b.addr = 16'h0000;
      bus_b.wdata = 8'h00;
      bus_b.wr = 1'b0;
      bus_b.rd = 1'b0;
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      bw(EEPAC_CTRL_ADDR, EEPAC_CTRL_PROGRAM);
      #1;
      chk(16'(lat_b), 16'h0001);
      chk(16'(pgm_b), 16'h0000);
      for (int i = 0; i < 4; i++) begin
         a = EEPAC_ARRAY_BASE + 16'($random(seed) & 'h1FF);
         o = 8'($random(seed));
         n = 8'($random(seed));
         m = 'hFF;
         op(o, 1'b1, 8'(m));
         m = m & o;
         op(o, 1'b0, 8'(m));
         m = m & n;
         op(n, 1'b0, 8'(m));
      end
      for (int i = 0; i < 4; i++) begin
         q.delete();
         hv_n = 0;
         @(posedge clk);
         erase_first <= 1'($random(seed));
         addr <= EEPAC_ARRAY_BASE + 16'($random(seed) & 'h1FF);
         data <= 8'($random(seed));
         start <= 1'b1;
         @(posedge clk);
         start <= 1'b0;
         #1;
         chk(16'(active), 16'h0001);
         k = 0;
         do begin
            @(posedge clk);
            #1;
            k++;
         end while (done !== 1'b1 && k < 200);
         chk(16'(done), 16'h0001);
         chk(16'(active), 16'h0000);
         ex.delete();
         if (erase_first) ex = {EEPAC_CTRL_ERASE_LAT, EEPAC_CTRL_ERASE_GO, EEPAC_CTRL_RESET};
         ex = {ex, EEPAC_CTRL_LATCH, EEPAC_CTRL_PROGRAM, EEPAC_CTRL_RESET};
         chk(16'(q.size()), 16'(ex.size()));
         foreach (ex[j]) chk(16'(q[j]), 16'(ex[j]));
         chk(16'(lwd), 16'(data));
         chk(16'(hv_n >= (erase_first ? 2 : 1) * HV), 16'h0001);
      end
      summarize();
   end
endmodule
